// *** design/dsa_ctrl.sv ***
// controller end: axi4-lite registers, word capture, serial sender
//
// Function
// - converter runs only from the supplied clock
// - signal integrate lasts ten thousand clocks
// - full conversion cycle is 40002 clocks
// - result count is 10000 times vin/vref
// - four bcd digits, half digit, polarity, overrange
// - overrange blinks blank and zero, switching at deintegrate
// - word is digit_drive[3:0] high, bcd low
// - polarity goes out through the parity select
// - received word starts measurement; busy clears ready
// - each strobe loads and sends one word
// - flags replace the top word's unused weights
// - each word finishes before the next strobe
// - parity setting captured when a word loads
// - processor bus gets flags in top word
// - controller starts or holds with run/hold
// - display driver blanks all five digits on alternate overrange cycles
// - top digit drive stays on when the half digit is zero
// - counter idles first deintegrate clock
`timescale 1ns/1ps
`include "dsa_defs.svh"
module dsa_ctrl
  import dsa_pkg::*;
#(
  parameter int BIT_CYCLES = `DSA_BIT_CYCLES
)(
  input wire logic aclk,
  input wire logic aresetn,
  dsa_link_if.ctrl link,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic serial_out
);
  // ------------------------------------------------------------
  // write channel: address and data taken in either order
  // ------------------------------------------------------------
  logic aw_hold_r, w_hold_r, bvalid_r;
  logic [7:0] awaddr_r;
  logic [3:0] wlo_r;
  logic wstrb0_r;
  logic [1:0] bresp_r;

  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready = !w_hold_r && !bvalid_r;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_fire = aw_hold_r && w_hold_r && !bvalid_r;

  wire wr_ctrl = awaddr_r == `DSA_ADDR_CTRL;
  wire wr_cmd = awaddr_r == `DSA_ADDR_CMD;
  wire wr_mask = awaddr_r == `DSA_ADDR_MASK;
  wire wr_ro = awaddr_r == `DSA_ADDR_STATUS ||
    awaddr_r == `DSA_ADDR_RESULT || awaddr_r == `DSA_ADDR_WORDS_LO ||
    awaddr_r == `DSA_ADDR_WORDS_HI;
  wire wr_ok = wr_ctrl || wr_cmd || wr_mask || wr_ro;
  wire wr_en = wr_fire && wstrb0_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      bvalid_r <= 1'b0;
      awaddr_r <= 8'h00;
      wlo_r <= 4'h0;
      wstrb0_r <= 1'b0;
      bresp_r <= `DSA_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_hold_r <= 1'b1;
        wlo_r <= s_axi_wdata[3:0];
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? `DSA_RESP_OKAY : `DSA_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // ------------------------------------------------------------
  // control, mask and measurement start
  // ------------------------------------------------------------
  logic [2:0] ctrl_r;
  logic [3:0] mask_r;
  logic ready_r, busy_q_r, run_hold_r;
  wire start = wr_en && wr_cmd && wlo_r[`DSA_CMD_START];
  wire busy_rise = link.busy && !busy_q_r;
  // a new start word wins over the busy edge that would clear it
  wire ready_nxt = start || (ready_r && !busy_rise);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `DSA_CTRL_RESET;
      mask_r <= 4'h0;
      ready_r <= 1'b0;
      busy_q_r <= 1'b0;
      run_hold_r <= 1'b0;
    end else begin
      if (wr_en && wr_ctrl) ctrl_r <= wlo_r[2:0];
      if (wr_en && wr_mask) mask_r <= wlo_r;
      ready_r <= ready_nxt;
      busy_q_r <= link.busy;
      run_hold_r <= ctrl_r[`DSA_CTRL_RUN] || ready_nxt;
    end
  end
  assign link.run_hold = run_hold_r;

  // ------------------------------------------------------------
  // word capture on each strobe
  // ------------------------------------------------------------
  logic [2:0] idx_r;
  logic [4:0][7:0] words_r;
  wire top = idx_r == 3'h0;
  // top digit weights two, four and eight are always zero
  wire [3:0] bcd_sel = (top && ctrl_r[`DSA_CTRL_MUX]) ?
    {link.underrange, link.overrange, link.polarity, link.bcd[0]} :
    link.bcd;
  wire dsa_word_t word_cur = {link.digit_drive[3:0], bcd_sel};
  wire last = link.strobe && idx_r == 3'h4;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idx_r <= 3'h0;
      words_r <= '0;
    end else if (busy_rise) begin
      idx_r <= 3'h0;
    end else if (link.strobe) begin
      words_r[idx_r] <= word_cur;
      idx_r <= last ? 3'h0 : idx_r + 3'h1;
    end
  end

  // ------------------------------------------------------------
  // serial sender
  // ------------------------------------------------------------
  logic tx_busy;
  wire tx_load = link.strobe && ctrl_r[`DSA_CTRL_TX];
  wire overrun = tx_load && tx_busy;

  dsa_uart_tx #(
    .BIT_CYCLES(BIT_CYCLES)
  ) u_tx (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(tx_load),
    .data(word_cur),
    .even_parity_select(link.polarity),
    .busy(tx_busy),
    .serial_out(serial_out)
  );

  // ------------------------------------------------------------
  // sticky status, cleared by reading it; set wins
  // ------------------------------------------------------------
  logic [3:0] status_r;
  wire [3:0] events = {overrun, last && link.underrange,
    last && link.overrange, last};
  wire rd_status = s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == `DSA_ADDR_STATUS;
  always_ff @(posedge aclk) begin
    if (!aresetn) status_r <= 4'h0;
    else status_r <= (rd_status ? 4'h0 : status_r) | events;
  end
  assign irq = |(status_r & mask_r);

  // ------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  assign s_axi_arready = !rvalid_r;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire [7:0] ra = s_axi_araddr;
  wire rd_ctrl = ra == `DSA_ADDR_CTRL;
  wire rd_cmd = ra == `DSA_ADDR_CMD;
  wire rd_stat = ra == `DSA_ADDR_STATUS;
  wire rd_mask = ra == `DSA_ADDR_MASK;
  wire rd_res = ra == `DSA_ADDR_RESULT;
  wire rd_wlo = ra == `DSA_ADDR_WORDS_LO;
  wire rd_whi = ra == `DSA_ADDR_WORDS_HI;
  wire rd_ok = rd_ctrl || rd_cmd || rd_stat || rd_mask || rd_res ||
    rd_wlo || rd_whi;
  wire [31:0] res_word = {8'h00, link.busy, link.underrange,
    link.overrange, link.polarity, words_r[0][3:0], words_r[1][3:0],
    words_r[2][3:0], words_r[3][3:0], words_r[4][3:0]};
  wire [31:0] rd_data =
    rd_ctrl ? {29'h0000_0000, ctrl_r} :
    rd_cmd ? {31'h0000_0000, ready_r} :
    rd_stat ? {28'h000_0000, status_r} :
    rd_mask ? {28'h000_0000, mask_r} :
    rd_res ? res_word :
    rd_wlo ? {words_r[3], words_r[2], words_r[1], words_r[0]} :
    rd_whi ? {24'h00_0000, words_r[4]} : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `DSA_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_data;
      rresp_r <= rd_ok ? `DSA_RESP_OKAY : `DSA_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
endmodule

// *** design/dsa_defs.svh ***
// constants shared by the converter end and the controller end
`ifndef DSA_DEFS_SVH
`define DSA_DEFS_SVH

// --------------------------------------------------------------
// conversion timing in converter clock periods, plus clock rate and digit count
// --------------------------------------------------------------
`define DSA_CONV_CLK_HZ 120000
`define DSA_INTEG_CYCLES 10000
`define DSA_CYCLE_CYCLES 40002
`define DSA_FULL_COUNT 20000
`define DSA_UNDER_COUNT 1800
`define DSA_DIGIT_CYCLES 200
`define DSA_NUM_DIGITS 5
`define DSA_BIT_CYCLES 16

// --------------------------------------------------------------
// controller register map (byte addresses)
// --------------------------------------------------------------
`define DSA_ADDR_CTRL 8'h00
`define DSA_ADDR_CMD 8'h04
`define DSA_ADDR_STATUS 8'h08
`define DSA_ADDR_MASK 8'h0C
`define DSA_ADDR_RESULT 8'h10
`define DSA_ADDR_WORDS_LO 8'h14
`define DSA_ADDR_WORDS_HI 8'h18

// --------------------------------------------------------------
// field positions, reset values and response codes
// --------------------------------------------------------------
`define DSA_CTRL_RUN 0
`define DSA_CTRL_MUX 1
`define DSA_CTRL_TX 2
`define DSA_CTRL_RESET 3'h6
`define DSA_CMD_START 0
`define DSA_ST_DONE 0
`define DSA_ST_OVER 1
`define DSA_ST_UNDER 2
`define DSA_ST_OVERRUN 3
`define DSA_RESP_OKAY 2'h0
`define DSA_RESP_SLVERR 2'h2

`endif

// *** design/dsa_pkg.sv ***
// types shared by both ends of the converter link
package dsa_pkg;
  typedef enum logic [1:0] {
    ST_AUTO_ZERO,
    ST_INTEGRATE,
    ST_DEINTEGRATE
  } dsa_state_e;
  typedef logic [3:0] dsa_bcd_t;
  typedef logic [7:0] dsa_word_t;
endpackage

// *** design/dsa_link_if.sv ***
// digit output link between the converter and its controller
`timescale 1ns/1ps
interface dsa_link_if;
  logic [4:0] digit_drive;
  logic [3:0] bcd;
  logic strobe;
  logic polarity;
  logic overrange;
  logic underrange;
  logic busy;
  logic run_hold;

  modport conv (
    output digit_drive,
    output bcd,
    output strobe,
    output polarity,
    output overrange,
    output underrange,
    output busy,
    input run_hold
  );
  modport ctrl (
    input digit_drive,
    input bcd,
    input strobe,
    input polarity,
    input overrange,
    input underrange,
    input busy,
    output run_hold
  );
endinterface

// *** design/dsa_uart_tx.sv ***
// serial word transmitter with parity captured at load
`timescale 1ns/1ps
`include "dsa_defs.svh"
module dsa_uart_tx
  import dsa_pkg::*;
#(
  parameter int BIT_CYCLES = `DSA_BIT_CYCLES
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire dsa_word_t data,
  input wire logic even_parity_select,
  output logic busy,
  output logic serial_out
);
  // ------------------------------------------------------------
  // frame: start, 8 data lsb first, parity, stop
  // ------------------------------------------------------------
  logic [10:0] shift_r;
  logic [3:0] bits_r;
  logic [15:0] tmr_r;
  logic out_r;

  wire parity_bit = even_parity_select ? ^data : ~^data;
  wire take = load && bits_r == 4'h0;
  wire bit_end = tmr_r == 16'(BIT_CYCLES - 1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_r <= 11'h7FF;
      bits_r <= 4'h0;
      tmr_r <= 16'h0000;
      out_r <= 1'b1;
    end else if (take) begin
      // parity select is frozen here for the whole word
      shift_r <= {1'b1, parity_bit, data, 1'b0};
      bits_r <= 4'hB;
      tmr_r <= 16'h0000;
      out_r <= 1'b0;
    end else if (bits_r != 4'h0) begin
      if (bit_end) begin
        tmr_r <= 16'h0000;
        bits_r <= bits_r - 4'h1;
        shift_r <= {1'b1, shift_r[10:1]};
        out_r <= (bits_r == 4'h1) ? 1'b1 : shift_r[1];
      end else begin
        tmr_r <= tmr_r + 16'h0001;
      end
    end
  end

  assign busy = bits_r != 4'h0;
  assign serial_out = out_r;
endmodule

// *** design/dsa_conv.sv ***
// converter end: phase sequencer, bcd counter and digit scan
`timescale 1ns/1ps
`include "dsa_defs.svh"
module dsa_conv
  import dsa_pkg::*;
#(
  parameter int INTEG_CYCLES = `DSA_INTEG_CYCLES,
  parameter int CYCLE_CYCLES = `DSA_CYCLE_CYCLES,
  parameter int FULL_COUNT = `DSA_FULL_COUNT,
  parameter int UNDER_COUNT = `DSA_UNDER_COUNT,
  parameter int DIGIT_CYCLES = `DSA_DIGIT_CYCLES
)(
  input wire logic aclk,
  input wire logic aresetn,
  dsa_link_if.conv link,
  input wire logic zero_cross,
  input wire logic input_negative,
  output logic [2:0] phase
);
  localparam int ND = `DSA_NUM_DIGITS;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] zc_sync_r;
  logic [1:0] neg_sync_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zc_sync_r <= 2'h0;
      neg_sync_r <= 2'h0;
    end else begin
      zc_sync_r <= {zc_sync_r[0], zero_cross};
      neg_sync_r <= {neg_sync_r[0], input_negative};
    end
  end
  wire zc_s = zc_sync_r[1];
  wire neg_s = neg_sync_r[1];

  // ------------------------------------------------------------
  // phase sequencer, all timing counted on aclk
  // ------------------------------------------------------------
  dsa_state_e state_r, state_nxt;
  logic [15:0] cyc_r;
  logic [14:0] cnt_bin_r;
  logic first_r;

  wire in_az = state_r == ST_AUTO_ZERO;
  wire in_int = state_r == ST_INTEGRATE;
  wire in_de = state_r == ST_DEINTEGRATE;
  wire cyc_end = cyc_r == 16'(CYCLE_CYCLES - 1);
  wire integ_end = in_int && cyc_r == 16'(INTEG_CYCLES - 1);
  wire full = cnt_bin_r == 15'(FULL_COUNT - 1);
  wire de_stop = in_de && !first_r && (zc_s || full);
  wire ovr_hit = full && !zc_s;
  wire count_inc = in_de && !first_r && !de_stop;
  wire hold = in_az && cyc_end && !link.run_hold;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_AUTO_ZERO: begin
        if (cyc_end && link.run_hold) state_nxt = ST_INTEGRATE;
      end
      ST_INTEGRATE: begin
        if (integ_end) state_nxt = ST_DEINTEGRATE;
      end
      ST_DEINTEGRATE: begin
        if (de_stop) state_nxt = ST_AUTO_ZERO;
      end
      default: state_nxt = ST_AUTO_ZERO;
    endcase
  end

  // auto-zero absorbs whatever deintegrate left, so every cycle is equal while run/hold stays high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_AUTO_ZERO;
      cyc_r <= 16'h0000;
      first_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (!hold) cyc_r <= cyc_end ? 16'h0000 : cyc_r + 16'h0001;
      first_r <= integ_end;
    end
  end

  // ------------------------------------------------------------
  // bcd count of deintegrate clocks
  // ------------------------------------------------------------
  logic [ND-1:0][3:0] cnt_d_r, cnt_d_nxt;
  logic [ND-1:0] carry;
  assign carry[0] = count_inc;
  for (genvar g = 0; g < ND; g++) begin : g_dig
    wire is9 = cnt_d_r[g] == 4'h9;
    assign cnt_d_nxt[g] = integ_end ? 4'h0 :
      carry[g] ? (is9 ? 4'h0 : cnt_d_r[g] + 4'h1) : cnt_d_r[g];
    if (g < ND - 1) begin : g_c
      assign carry[g + 1] = carry[g] && is9;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_d_r <= '0;
      cnt_bin_r <= 15'h0000;
    end else begin
      cnt_d_r <= cnt_d_nxt;
      if (integ_end) cnt_bin_r <= 15'h0000;
      else if (count_inc) cnt_bin_r <= cnt_bin_r + 15'h0001;
    end
  end

  // ------------------------------------------------------------
  // result latch and overrange blink
  // ------------------------------------------------------------
  logic [ND-1:0][3:0] res_d_r;
  logic pol_int_r, pol_r, ovr_r, und_r, blank_r, busy_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_d_r <= '0;
      pol_int_r <= 1'b1;
      pol_r <= 1'b1;
      ovr_r <= 1'b0;
      und_r <= 1'b0;
      blank_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      busy_r <= state_nxt != ST_AUTO_ZERO;
      if (integ_end) begin
        pol_int_r <= !neg_s;
        blank_r <= ovr_r ? !blank_r : 1'b0;
      end
      if (de_stop) begin
        res_d_r <= ovr_hit ? '0 : cnt_d_r;
        pol_r <= pol_int_r;
        ovr_r <= ovr_hit;
        und_r <= !ovr_hit && cnt_bin_r < 15'(UNDER_COUNT);
      end
    end
  end

  // ------------------------------------------------------------
  // digit scan, msd first; strobes only on the first pass
  // ------------------------------------------------------------
  logic [2:0] dig_r;
  logic [15:0] dcnt_r;
  logic strobe_en_r, strobe_r;
  logic [4:0] drive_r;
  dsa_bcd_t bcd_r;
  wire dig_end = dcnt_r == 16'(DIGIT_CYCLES - 1);
  wire mid = dcnt_r == 16'(DIGIT_CYCLES / 2);
  // a reading back in range shows at once, even on a blank turn
  wire show_blank = blank_r && ovr_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dig_r <= 3'h4;
      dcnt_r <= 16'h0000;
      strobe_en_r <= 1'b0;
      strobe_r <= 1'b0;
      drive_r <= 5'h00;
      bcd_r <= 4'h0;
    end else begin
      if (de_stop) begin
        dig_r <= 3'h4;
        dcnt_r <= 16'h0000;
        strobe_en_r <= 1'b1;
      end else if (dig_end) begin
        dcnt_r <= 16'h0000;
        dig_r <= (dig_r == 3'h0) ? 3'h4 : dig_r - 3'h1;
        if (dig_r == 3'h0) strobe_en_r <= 1'b0;
      end else begin
        dcnt_r <= dcnt_r + 16'h0001;
      end
      // drive and bcd settle half a digit before the strobe
      drive_r <= show_blank ? 5'h00 : 5'h01 << dig_r;
      bcd_r <= res_d_r[dig_r];
      strobe_r <= strobe_en_r && mid && !de_stop;
    end
  end

  assign link.digit_drive = drive_r;
  assign link.bcd = bcd_r;
  assign link.strobe = strobe_r;
  assign link.polarity = pol_r;
  assign link.overrange = ovr_r;
  assign link.underrange = und_r;
  assign link.busy = busy_r;
  assign phase = {in_de, in_int, in_az};
endmodule

// *** tb/dsa_link_asserts.sv ***
// concurrent checks on the digit link between converter and controller
`timescale 1ns/1ps
`include "dsa_defs.svh"
module dsa_link_asserts #(
  parameter int INTEG_CYCLES = `DSA_INTEG_CYCLES,
  parameter int CYCLE_CYCLES = `DSA_CYCLE_CYCLES,
  parameter int DIGIT_CYCLES = `DSA_DIGIT_CYCLES
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [4:0] digit_drive,
  input wire logic [3:0] bcd,
  input wire logic strobe,
  input wire logic overrange,
  input wire logic busy,
  input wire logic run_hold
);
  // ------------------------------------------------------------
  // helper counters
  // ------------------------------------------------------------
  logic busy_q_r;
  logic seen_r;
  logic hold_ok_r;
  logic [15:0] pcnt_r;
  logic [15:0] bcnt_r;
  logic [15:0] gcnt_r;
  logic [2:0] scnt_r;
  wire busy_rise = busy && !busy_q_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q_r <= 1'b0;
      seen_r <= 1'b0;
      hold_ok_r <= 1'b0;
      pcnt_r <= 16'h0000;
      bcnt_r <= 16'h0000;
      gcnt_r <= 16'h0000;
      scnt_r <= 3'h0;
    end else begin
      busy_q_r <= busy;
      seen_r <= seen_r | busy_rise;
      // period is only fixed while run stays asserted the whole time
      hold_ok_r <= busy_rise ? run_hold : (hold_ok_r & run_hold);
      pcnt_r <= busy_rise ? 16'h0001 : pcnt_r + 16'h0001;
      bcnt_r <= busy ? bcnt_r + 16'h0001 : 16'h0000;
      gcnt_r <= strobe ? 16'h0001 : gcnt_r + 16'h0001;
      scnt_r <= busy_rise ? 3'h0 : scnt_r + {2'h0, strobe};
    end
  end

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_held;
    $stable(digit_drive) && $stable(bcd);
  endsequence

  a_strobe_pulse: assert property (strobe |=> !strobe)
    else $error("strobe longer than one cycle");
  a_strobe_held: assert property (strobe |-> s_held ##1 s_held)
    else $error("digit outputs moved around strobe");
  a_scan_order: assert property (strobe && !overrange |->
    digit_drive == (5'b10000 >> scnt_r))
    else $error("digit drive out of scan order");
  a_strobe_once: assert property (strobe |-> scnt_r < 3'h5)
    else $error("more than five strobes in one conversion");
  a_strobe_gap: assert property (strobe && scnt_r != 3'h0 |->
    gcnt_r == DIGIT_CYCLES)
    else $error("strobe spacing wrong");
  a_cycle_len: assert property ($rose(busy) && seen_r && hold_ok_r |->
    pcnt_r == CYCLE_CYCLES)
    else $error("conversion period wrong");
  a_integ_min: assert property ($fell(busy) |-> bcnt_r > INTEG_CYCLES)
    else $error("busy shorter than integrate phase");
  a_hold_park: assert property ($rose(busy) |-> $past(run_hold))
    else $error("conversion started while held");
  a_over_zero: assert property (strobe && overrange |-> bcd == 4'h0)
    else $error("overrange digit not zero");
endmodule

// *** tb/dual_slope_adc_digit_output_interface_tb.sv ***
// bench: converter and controller joined, driven over axi4-lite
`timescale 1ns/1ps
`include "dsa_defs.svh"
module dual_slope_adc_digit_output_interface_tb;
  localparam int DIG = 40;
  // the five-digit scan must end before the next integrate starts
  localparam int CYC = 300;
  logic aclk, aresetn, input_negative, irq, serial_out;
  logic zero_cross = 1'b0;
  logic [2:0] phase;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic drv_acc = 1'b0;
  logic busy_q = 1'b0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [1:0] blink_h = 2'h0;
  logic [10:0] ser_w = 11'h000;
  int n_errors, compares, zc_at;
  int cyc_cnt = 0;
  int dcnt = 0;
  int ser_cnt = 0;

  dsa_link_if u_dsa_link_if ();
  dsa_conv #(.INTEG_CYCLES(20), .CYCLE_CYCLES(CYC), .FULL_COUNT(50),
    .UNDER_COUNT(5), .DIGIT_CYCLES(DIG)) u_dsa_conv (.aclk, .aresetn,
    .link(u_dsa_link_if.conv), .zero_cross, .input_negative, .phase);
  dsa_ctrl #(.BIT_CYCLES(2)) u_dsa_ctrl (.aclk, .aresetn,
    .link(u_dsa_link_if.ctrl), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .serial_out);
  dsa_link_asserts #(.INTEG_CYCLES(20), .CYCLE_CYCLES(CYC),
    .DIGIT_CYCLES(DIG)) u_dsa_link_asserts (.aclk, .aresetn,
    .digit_drive(u_dsa_link_if.digit_drive), .bcd(u_dsa_link_if.bcd),
    .strobe(u_dsa_link_if.strobe), .overrange(u_dsa_link_if.overrange),
    .busy(u_dsa_link_if.busy), .run_hold(u_dsa_link_if.run_hold));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // ------------------------------------------------------------
  // comparator model, blink monitor, watchdog
  // ------------------------------------------------------------
  always @(posedge aclk) begin
    dcnt <= phase[2] ? dcnt + 1 : 0;
    zero_cross <= phase[2] && dcnt >= zc_at;
    busy_q <= u_dsa_link_if.busy;
    // only the idle scan counts: the blink flips inside busy
    if (u_dsa_link_if.busy && !busy_q) begin
      blink_h <= {blink_h[0], drv_acc};
      drv_acc <= 1'b0;
    end else begin
      drv_acc <= drv_acc | (!u_dsa_link_if.busy &&
        |u_dsa_link_if.digit_drive);
    end
    // frame sampler: second cycle of every two-cycle bit, lsb first
    if (ser_cnt == 0 && serial_out === 1'b0) ser_cnt <= 1;
    else if (ser_cnt != 0) begin
      ser_cnt <= (ser_cnt == 21) ? 0 : ser_cnt + 1;
      if (ser_cnt[0]) ser_w <= {serial_out, ser_w[10:1]};
    end
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wait_irq;
    while (irq !== 1'b1) @(posedge aclk);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    int cnt;
    {aresetn, input_negative, s_axi_awvalid} = 3'h0;
    {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 52'h0;
    {n_errors, compares} = 64'h0;
    zc_at = 37;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdr(`DSA_ADDR_CTRL);
    check(rd, 32'h0000_0006);
    check(u_dsa_link_if.run_hold, 1'b0);
    repeat (3 * CYC) @(posedge aclk);
    check(u_dsa_link_if.busy, 1'b0);
    rdr(8'h1C);
    check(rs, 2'h2);
    check(rd, 32'h0000_0000);
    wr(`DSA_ADDR_MASK, 32'h0000_0001);
    check(rs, 2'h0);
    wr(`DSA_ADDR_CMD, 32'h0000_0001);
    wait_irq();
    rdr(`DSA_ADDR_STATUS);
    check(rd, 32'h0000_0001);
    rdr(`DSA_ADDR_STATUS);
    check(irq, 1'b0);
    check(rd, 32'h0000_0000);
    rdr(`DSA_ADDR_RESULT);
    check(rd[23:16], 8'h12);
    cnt = rd[15:12] * 1000 + rd[11:8] * 100 + rd[7:4] * 10 + rd[3:0];
    check(32'(cnt >= zc_at - 2 && cnt <= zc_at + 3), 32'h1);
    rdr(`DSA_ADDR_WORDS_LO);
    check({rd[31:28], rd[23:20], rd[15:12], rd[7:0]}, 32'h2_4802);
    rdr(`DSA_ADDR_WORDS_HI);
    check(rd[7:4], 4'h1);
    // last word 0x19 sent with even parity for a positive reading
    repeat (24) @(posedge aclk);
    check(ser_w, 11'h632);
    // overrange in free run: no zero crossing, negative input
    zc_at = 100000;
    input_negative <= 1'b1;
    wr(`DSA_ADDR_MASK, 32'h0000_0002);
    wr(`DSA_ADDR_CTRL, 32'h0000_0007);
    wait_irq();
    rdr(`DSA_ADDR_STATUS);
    check(rd, 32'h0000_0003);
    repeat (3 * CYC + 20) @(posedge aclk);
    check(^blink_h, 1'b1);
    rdr(`DSA_ADDR_RESULT);
    check(rd[22:0], 32'h0024_0000);
    // hold with flag mux off, then one commanded underrange conversion
    wr(`DSA_ADDR_CTRL, 32'h0000_0004);
    zc_at = 0;
    input_negative <= 1'b0;
    wr(`DSA_ADDR_MASK, 32'h0000_0004);
    repeat (3 * CYC) @(posedge aclk);
    rdr(`DSA_ADDR_STATUS);
    repeat (2 * CYC) @(posedge aclk);
    check({irq, u_dsa_link_if.busy}, 2'h0);
    wr(`DSA_ADDR_CMD, 32'h0000_0001);
    wait_irq();
    rdr(`DSA_ADDR_STATUS);
    check(rd, 32'h0000_0005);
    rdr(`DSA_ADDR_RESULT);
    check(rd[22:0], 32'h0050_0002);
    print_verdict();
  end
endmodule
